//--- design/core_pointer_power_regs.sv
// core stack, data pointer, port 0 and power control registers
//
// Function
// - stack pointer resets 07h, pre-increment, post-decrement
// - first pushed byte lands above pointer
// - each pointer is low plus high byte
// - select bit chooses first or second pair
// - baud doubler doubles serial port 0 rate
// - two user flags are plain storage
// - stop write halts all clocked logic
// - stop bit always reads zero
// - stop holds outputs, only reset exits
// - idle freezes cpu, timers, serial ports
// - idle bit always reads zero
// - idle ends on aux or enabled wakeup
// - port 0 address while strobe high, data low
// - gpio drive set by direction registers
// - config bit 1 picks gpio or bus
// - mode bit 0 bus, 1 gpio default
`timescale 1ns/1ps
module core_pointer_power_regs (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic stack_push,
	input wire logic stack_pop,
	output logic [7:0] stack_write_addr,
	output logic [7:0] stack_read_addr,
	input wire logic active_data_pointer_load,
	input wire logic [15:0] active_data_pointer_load_value,
	input wire logic active_data_pointer_inc,
	output logic [15:0] active_data_pointer,
	output logic baud_doubler,
	input wire logic [7:0] hardware_config_second,
	input wire logic [7:0] port0_direction_low,
	input wire logic [7:0] port0_direction_high,
	input wire logic ext_start,
	input wire logic ext_write,
	input wire logic [7:0] ext_addr_low,
	input wire logic [7:0] ext_wdata,
	output logic [7:0] ext_rdata,
	output logic ext_done,
	output logic addr_latch_strobe,
	output logic ext_wr_strobe_b,
	output logic ext_rd_strobe_b,
	output logic port0_gpio_select,
	input wire logic [7:0] port0_pad_in,
	output logic [7:0] port0_pad_out,
	output logic [7:0] port0_pad_oe,
	output logic [7:0] port0_pin_value,
	input wire logic auxiliary_interrupt,
	input wire logic wakeup_enable,
	input wire logic wakeup_event,
	output logic osc_stop,
	output logic idle_freeze
);
	logic [7:0] port0_latch;
	logic [7:0] stack_pointer;
	logic [7:0] data_pointer0_low;
	logic [7:0] data_pointer0_high;
	logic [7:0] data_pointer1_low;
	logic [7:0] data_pointer1_high;
	logic data_pointer_select;
	logic user_flag_one;
	logic user_flag_zero;
	core_regs_pkg::power_state_type power_state;
	core_regs_pkg::ext_phase_type ext_phase;
	logic [7:0] pin_s1;
	logic [7:0] pin_s2;
	logic [7:0] pin_s3;
	logic ext_write_q;
	logic [7:0] ext_wdata_q;
	logic run;
	logic cpu_run;
	logic stop_req;
	logic idle_req;
	logic [15:0] next_active_data_pointer;
	// combinational next values and pad drive
	logic [7:0] next_stack_pointer;
	logic [7:0] next_rdata;
	logic [7:0] pin_agree;
	logic bus_drive;
	logic [7:0] bus_value;

	// a write strobe aimed at one address; shared by every register
	function automatic logic hit(input logic [7:0] a);
		hit = sfr_wr && (sfr_addr == a);
	endfunction

	// stop gates everything; idle only gates the cpu-side registers
	assign run = clk_en && (power_state != core_regs_pkg::PWR_STOP);
	assign cpu_run = run && (power_state == core_regs_pkg::PWR_RUN);
	assign osc_stop = (power_state == core_regs_pkg::PWR_STOP);
	assign idle_freeze = (power_state == core_regs_pkg::PWR_IDLE);

	assign stop_req = cpu_run && hit(core_regs_pkg::ADDR_PWR)
		&& sfr_wdata[core_regs_pkg::PWR_STOP_BIT];
	assign idle_req = cpu_run && hit(core_regs_pkg::ADDR_PWR)
		&& sfr_wdata[core_regs_pkg::PWR_IDLE_BIT];

	// stop is left only through reset; idle ends on the auxiliary interrupt or an enabled wakeup
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			power_state <= core_regs_pkg::PWR_RUN;
		end else if (clk_en) begin
			unique case (power_state)
				core_regs_pkg::PWR_RUN: begin
					if (stop_req) begin
						power_state <= core_regs_pkg::PWR_STOP;
					end else if (idle_req) begin
						power_state <= core_regs_pkg::PWR_IDLE;
					end
				end
				core_regs_pkg::PWR_IDLE: begin
					if (auxiliary_interrupt
						|| (wakeup_enable && wakeup_event)) begin
						power_state <= core_regs_pkg::PWR_RUN;
					end
				end
				core_regs_pkg::PWR_STOP: begin
					power_state <= core_regs_pkg::PWR_STOP;
				end
				default: power_state <= core_regs_pkg::PWR_RUN;
			endcase
		end
	end

	// push and pop from the cpu take priority over a register write
	// both at once cancel, and a write in that cycle is dropped as well
	always_comb begin
		next_stack_pointer = stack_pointer;
		if (stack_push && !stack_pop) begin
			next_stack_pointer = stack_pointer + 8'h01;
		end else if (stack_pop && !stack_push) begin
			next_stack_pointer = stack_pointer - 8'h01;
		end else if (!stack_push && hit(core_regs_pkg::ADDR_SP)) begin
			next_stack_pointer = sfr_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			stack_pointer <= core_regs_pkg::RST_SP;
		end else if (cpu_run) begin
			stack_pointer <= next_stack_pointer;
		end
	end
	// pre-increment: a push writes one above the current pointer
	assign stack_write_addr = stack_pointer + 8'h01;
	assign stack_read_addr = stack_pointer;

	// the select bit swaps the whole pair, never single bytes
	assign active_data_pointer = data_pointer_select
		? {data_pointer1_high, data_pointer1_low}
		: {data_pointer0_high, data_pointer0_low};
	// load beats increment; both act on the pair in use
	assign next_active_data_pointer = active_data_pointer_load ? active_data_pointer_load_value
		: active_data_pointer + 16'h0001;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_pointer0_low <= core_regs_pkg::RST_DP;
			data_pointer0_high <= core_regs_pkg::RST_DP;
		end else if (cpu_run) begin
			if ((active_data_pointer_load || active_data_pointer_inc) && !data_pointer_select) begin
				data_pointer0_low <= next_active_data_pointer[7:0];
				data_pointer0_high <= next_active_data_pointer[15:8];
			end else begin
				if (hit(core_regs_pkg::ADDR_DP0L)) begin
					data_pointer0_low <= sfr_wdata;
				end
				if (hit(core_regs_pkg::ADDR_DP0H)) begin
					data_pointer0_high <= sfr_wdata;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_pointer1_low <= core_regs_pkg::RST_DP;
			data_pointer1_high <= core_regs_pkg::RST_DP;
		end else if (cpu_run) begin
			if ((active_data_pointer_load || active_data_pointer_inc) && data_pointer_select) begin
				data_pointer1_low <= next_active_data_pointer[7:0];
				data_pointer1_high <= next_active_data_pointer[15:8];
			end else begin
				if (hit(core_regs_pkg::ADDR_DP1L)) begin
					data_pointer1_low <= sfr_wdata;
				end
				if (hit(core_regs_pkg::ADDR_DP1H)) begin
					data_pointer1_high <= sfr_wdata;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_pointer_select <= 1'b0;
		end else if (cpu_run && hit(core_regs_pkg::ADDR_DPSEL)) begin
			data_pointer_select <= sfr_wdata[0];
		end
	end

	// stop and idle bits are never stored
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			baud_doubler <= core_regs_pkg::RST_PWR[core_regs_pkg::PWR_BAUD_BIT];
			user_flag_one <= core_regs_pkg::RST_PWR[core_regs_pkg::PWR_FLAG1_BIT];
			user_flag_zero <= core_regs_pkg::RST_PWR[core_regs_pkg::PWR_FLAG0_BIT];
		end else if (cpu_run && hit(core_regs_pkg::ADDR_PWR)) begin
			baud_doubler <= sfr_wdata[core_regs_pkg::PWR_BAUD_BIT];
			user_flag_one <= sfr_wdata[core_regs_pkg::PWR_FLAG1_BIT];
			user_flag_zero <= sfr_wdata[core_regs_pkg::PWR_FLAG0_BIT];
		end
	end

	// in gpio mode the latch drives the pads; reads return the filtered pins
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			port0_latch <= core_regs_pkg::RST_PORT0;
		end else if (cpu_run && hit(core_regs_pkg::ADDR_PORT0)) begin
			port0_latch <= sfr_wdata;
		end
	end

	// a bit follows its pin only once two stages agree
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_agree
			assign pin_agree[b] = (pin_s2[b] == pin_s3[b]);
		end
	endgenerate

	// pins from outside: three stages, change taken when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_s1 <= 8'hFF;
			pin_s2 <= 8'hFF;
			pin_s3 <= 8'hFF;
			port0_pin_value <= 8'hFF;
		end else if (run) begin
			pin_s1 <= port0_pad_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			port0_pin_value <= (port0_pin_value & ~pin_agree)
				| (pin_s3 & pin_agree);
		end
	end

	assign port0_gpio_select =
		hardware_config_second[core_regs_pkg::CFG_GPIO_BIT];

	// external cycle: one address phase with strobe high, then one data phase
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ext_phase <= core_regs_pkg::EXT_IDLE;
			ext_write_q <= 1'b0;
			ext_wdata_q <= 8'h00;
			ext_rdata <= 8'h00;
			ext_done <= 1'b0;
		end else if (cpu_run) begin
			ext_done <= 1'b0;
			unique case (ext_phase)
				core_regs_pkg::EXT_IDLE: begin
					if (ext_start && !port0_gpio_select) begin
						ext_phase <= core_regs_pkg::EXT_ADDR;
						ext_write_q <= ext_write;
						ext_wdata_q <= ext_wdata;
					end
				end
				core_regs_pkg::EXT_ADDR: begin
					ext_phase <= core_regs_pkg::EXT_DATA;
				end
				core_regs_pkg::EXT_DATA: begin
					// raw pad sampled: the strobe timing is ours, no metastable hazard
					if (!ext_write_q) begin
						ext_rdata <= port0_pad_in;
					end
					ext_done <= 1'b1;
					ext_phase <= core_regs_pkg::EXT_IDLE;
				end
				default: ext_phase <= core_regs_pkg::EXT_IDLE;
			endcase
		end
	end

	assign addr_latch_strobe = (ext_phase == core_regs_pkg::EXT_ADDR);
	assign ext_wr_strobe_b = !((ext_phase == core_regs_pkg::EXT_DATA)
		&& ext_write_q);
	assign ext_rd_strobe_b = !((ext_phase == core_regs_pkg::EXT_DATA)
		&& !ext_write_q);

	// write data is driven only in a write's data phase; reads leave it free
	assign bus_drive = addr_latch_strobe
		|| ((ext_phase == core_regs_pkg::EXT_DATA) && ext_write_q);
	assign bus_value = addr_latch_strobe ? ext_addr_low : ext_wdata_q;

	// pads are combinational on held registers, so stop keeps them still
	port0_pad_ctrl u_pad (
		.gpio_mode(port0_gpio_select),
		.latch(port0_latch),
		.direction_low(port0_direction_low),
		.direction_high(port0_direction_high),
		.bus_drive(bus_drive),
		.bus_value(bus_value),
		.pad_out(port0_pad_out),
		.pad_oe(port0_pad_oe)
	);

	// read data registered; stop and idle bits read back as zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (sfr_addr)
			core_regs_pkg::ADDR_PORT0: next_rdata = port0_pin_value;
			core_regs_pkg::ADDR_SP: next_rdata = stack_pointer;
			core_regs_pkg::ADDR_DP0L: next_rdata = data_pointer0_low;
			core_regs_pkg::ADDR_DP0H: next_rdata = data_pointer0_high;
			core_regs_pkg::ADDR_DP1L: next_rdata = data_pointer1_low;
			core_regs_pkg::ADDR_DP1H: next_rdata = data_pointer1_high;
			core_regs_pkg::ADDR_DPSEL: next_rdata = {7'h00, data_pointer_select};
			core_regs_pkg::ADDR_PWR: next_rdata = core_regs_pkg::PWR_FIXED
				| {baud_doubler, 3'b000, user_flag_one, user_flag_zero,
				2'b00};
			// unmapped addresses read as zero
			default: next_rdata = 8'h00;
		endcase
	end

	// a read in idle or stop is refused and the old data stands
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
		end else if (cpu_run && sfr_rd) begin
			sfr_rdata <= next_rdata;
		end
	end
endmodule

//--- design/core_regs_pkg.sv
// shared constants for the core pointer and power register group
package core_regs_pkg;
	localparam logic [7:0] ADDR_PORT0 = 8'h80;
	localparam logic [7:0] ADDR_SP = 8'h81;
	localparam logic [7:0] ADDR_DP0L = 8'h82;
	localparam logic [7:0] ADDR_DP0H = 8'h83;
	localparam logic [7:0] ADDR_DP1L = 8'h84;
	localparam logic [7:0] ADDR_DP1H = 8'h85;
	localparam logic [7:0] ADDR_DPSEL = 8'h86;
	localparam logic [7:0] ADDR_PWR = 8'h87;
	localparam logic [7:0] RST_PORT0 = 8'hFF;
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] RST_DP = 8'h00;
	localparam logic [7:0] RST_PWR = 8'h30;
	localparam int PWR_BAUD_BIT = 7;
	localparam int PWR_FLAG1_BIT = 3;
	localparam int PWR_FLAG0_BIT = 2;
	localparam int PWR_STOP_BIT = 1;
	localparam int PWR_IDLE_BIT = 0;
	localparam logic [7:0] PWR_FIXED = 8'h30;
	localparam int CFG_GPIO_BIT = 1;
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_IDLE = 2'b01,
		PWR_STOP = 2'b10
	} power_state_type;
	typedef enum logic [1:0] {
		EXT_IDLE = 2'b00,
		EXT_ADDR = 2'b01,
		EXT_DATA = 2'b10
	} ext_phase_type;
endpackage

//--- design/port0_pad_ctrl.sv
// port 0 pad drive: gpio drive types or multiplexed external bus
`timescale 1ns/1ps
module port0_pad_ctrl (
	input wire logic gpio_mode,
	input wire logic [7:0] latch,
	input wire logic [7:0] direction_low,
	input wire logic [7:0] direction_high,
	input wire logic bus_drive,
	input wire logic [7:0] bus_value,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe
);
	logic [15:0] dir;
	assign dir = {direction_high, direction_low};
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			// two bits per pin: 00 in, 01 push-pull, 10 open drain, 11 weak
			always_comb begin
				pad_out[i] = latch[i];
				pad_oe[i] = 1'b0;
				if (!gpio_mode) begin
					pad_out[i] = bus_value[i];
					pad_oe[i] = bus_drive;
				end else begin
					unique case (dir[2*i+1 -: 2])
						2'b00: pad_oe[i] = 1'b0;
						2'b01: pad_oe[i] = 1'b1;
						2'b10: pad_oe[i] = ~latch[i];
						2'b11: pad_oe[i] = latch[i];
					endcase
				end
			end
		end
	endgenerate
endmodule

//--- tb/ext_mem_model.sv
// external memory on the multiplexed port 0 bus
`timescale 1ns/1ps
module ext_mem_model (
	input wire logic sys_clk,
	input wire logic addr_latch_strobe,
	input wire logic ext_wr_strobe_b,
	input wire logic ext_rd_strobe_b,
	input wire logic [7:0] bus,
	output logic [7:0] drive
);
	logic [7:0] mem [256];
	logic [7:0] addr;
	logic [7:0] last = 8'h00;
	always @(posedge sys_clk) begin
		if (addr_latch_strobe)
			addr <= bus;
		if (!ext_wr_strobe_b)
			mem[addr] <= bus;
		last <= drive;
	end
	// released bus keeps changing so stale data cannot pass
	assign drive = !ext_rd_strobe_b ? mem[addr] : ~last;
endmodule

//--- tb/core_regs_checker.sv
// port assertions for the core pointer and power registers
`timescale 1ns/1ps
module core_regs_checker (
	input wire logic sys_clk, rst_b, clk_en, sfr_wr, sfr_rd, stack_push,
	input wire logic stack_pop, baud_doubler, ext_start, ext_done,
	input wire logic addr_latch_strobe, ext_wr_strobe_b, ext_rd_strobe_b,
	input wire logic port0_gpio_select, auxiliary_interrupt, wakeup_enable,
	input wire logic wakeup_event, osc_stop, idle_freeze,
	input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, stack_read_addr,
	input wire logic [7:0] stack_write_addr, hardware_config_second,
	input wire logic [7:0] ext_addr_low, port0_pad_out, port0_pad_oe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// idle blocks every cpu-side update and stop blocks all, not only bus access
	wire run = clk_en && !idle_freeze && !osc_stop;
	wire pw = run && sfr_wr && sfr_addr == core_regs_pkg::ADDR_PWR;
	wire pr = run && sfr_rd && sfr_addr == core_regs_pkg::ADDR_PWR;
	wire wake = auxiliary_interrupt || (wakeup_enable && wakeup_event);
	wire quiet = !addr_latch_strobe && ext_wr_strobe_b && ext_rd_strobe_b;
	property p_push;
		run && stack_push && !stack_pop && !sfr_wr |=>
			stack_read_addr == $past(stack_read_addr) + 8'h01;
	endproperty
	a_push: assert property (p_push) else $error("push");
	property p_above;
		stack_write_addr == stack_read_addr + 8'h01;
	endproperty
	a_above: assert property (p_above) else $error("above");
	property p_baud;
		pw && !sfr_wdata[1] |=> baud_doubler == $past(sfr_wdata[7]);
	endproperty
	a_baud: assert property (p_baud) else $error("baud");
	property p_stop;
		pw && sfr_wdata[1] |=> osc_stop && !idle_freeze;
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_hold;
		osc_stop |=> osc_stop && $stable(port0_pad_out) && $stable(sfr_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_frozen;
		idle_freeze && clk_en && !wake |=>
			idle_freeze && $stable(stack_read_addr);
	endproperty
	a_frozen: assert property (p_frozen) else $error("frozen");
	property p_wake;
		idle_freeze && clk_en && wake |=> !idle_freeze;
	endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_read0;
		pr |=> sfr_rdata[1:0] == 2'b00 && sfr_rdata[6:4] == 3'b011;
	endproperty
	a_read0: assert property (p_read0) else $error("read0");
	property p_ext;
		run && ext_start && !port0_gpio_select && quiet |=> addr_latch_strobe
			##1 ext_rd_strobe_b != ext_wr_strobe_b ##1 ext_done;
	endproperty
	a_ext: assert property (p_ext) else $error("ext");
	property p_addr;
		addr_latch_strobe |-> port0_pad_oe == 8'hFF &&
			port0_pad_out == ext_addr_low;
	endproperty
	a_addr: assert property (p_addr) else $error("addr");
	property p_mode;
		port0_gpio_select == hardware_config_second[1];
	endproperty
	a_mode: assert property (p_mode) else $error("mode");
	c_stop: cover property (pw && sfr_wdata[1] ##1 osc_stop);
	c_wake: cover property (idle_freeze ##1 !idle_freeze);
	c_ext: cover property (addr_latch_strobe ##2 ext_done);
endmodule
bind core_pointer_power_regs core_regs_checker watch (.sys_clk, .rst_b,
	.clk_en, .sfr_wr, .sfr_rd, .stack_push, .stack_pop, .baud_doubler,
	.ext_start, .ext_done, .addr_latch_strobe, .ext_wr_strobe_b,
	.ext_rd_strobe_b, .port0_gpio_select, .auxiliary_interrupt,
	.wakeup_enable, .wakeup_event, .osc_stop, .idle_freeze, .sfr_addr,
	.sfr_wdata, .sfr_rdata, .stack_read_addr, .stack_write_addr,
	.hardware_config_second, .ext_addr_low, .port0_pad_out, .port0_pad_oe);

//--- tb/core_pointer_power_regs_test.sv
// self-checking bench for the core pointer and power registers
`timescale 1ns/1ps
module core_pointer_power_regs_test;
	logic sys_clk, rst_b, clk_en, sfr_wr, sfr_rd, stack_push, stack_pop;
	logic active_data_pointer_load, active_data_pointer_inc, baud_doubler, ext_start, ext_write, ext_done;
	logic addr_latch_strobe, ext_wr_strobe_b, ext_rd_strobe_b, osc_stop;
	logic port0_gpio_select, auxiliary_interrupt, wakeup_enable;
	logic wakeup_event, idle_freeze;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, stack_write_addr, mem_q;
	logic [7:0] stack_read_addr, hardware_config_second, port0_pin_value;
	logic [7:0] port0_direction_low, port0_direction_high, ext_addr_low;
	logic [7:0] ext_wdata, ext_rdata, port0_pad_out, port0_pad_oe;
	logic [15:0] active_data_pointer_load_value, active_data_pointer;
	logic [7:0] rv [8] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h30};
	wire [7:0] pad = (port0_pad_oe & port0_pad_out) | (~port0_pad_oe & mem_q);
	int errors, num_checks;
	core_pointer_power_regs dut (.sys_clk, .rst_b, .clk_en, .sfr_addr,
		.sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .stack_push, .stack_pop,
		.stack_write_addr, .stack_read_addr, .active_data_pointer_load, .active_data_pointer_load_value,
		.active_data_pointer_inc, .active_data_pointer, .baud_doubler,
		.hardware_config_second, .port0_direction_low, .port0_direction_high,
		.ext_start, .ext_write, .ext_addr_low, .ext_wdata, .ext_rdata,
		.ext_done, .addr_latch_strobe, .ext_wr_strobe_b, .ext_rd_strobe_b,
		.port0_gpio_select, .port0_pad_in(pad), .port0_pad_out,
		.port0_pad_oe, .port0_pin_value, .auxiliary_interrupt,
		.wakeup_enable, .wakeup_event, .osc_stop, .idle_freeze);
	ext_mem_model mem (.sys_clk, .addr_latch_strobe, .ext_wr_strobe_b,
		.ext_rd_strobe_b, .bus(pad), .drive(mem_q));
	always #12.5 sys_clk = ~sys_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc(1);
		sfr_wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a);
		sfr_addr = a;
		sfr_rd = 1'b1;
		cyc(1);
		sfr_rd = 1'b0;
		cyc(1);
	endtask
	task automatic do_reset;
		rst_b = 1'b0;
		cyc(16);
		rst_b = 1'b1;
		cyc(5);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			rd(8'h80 + 8'(i));
			chk(sfr_rdata, rv[i]);
		end
		rd(8'h88);
		chk(sfr_rdata, 8'h00);
		$display("reset done");
	endtask
	task automatic t_stack;
		stack_push = 1'b1;
		cyc(2);
		stack_push = 1'b0;
		chk(stack_read_addr, 8'h09);
		chk(stack_write_addr, 8'h0A);
		{clk_en, stack_pop} = 2'b01;
		cyc(1);
		chk(stack_read_addr, 8'h09);
		clk_en = 1'b1;
		cyc(1);
		{stack_push, stack_pop} = 2'b11;
		cyc(1);
		{stack_push, stack_pop} = 2'b00;
		chk(stack_read_addr, 8'h08);
		wr(8'h81, 8'h20);
		chk(stack_write_addr, 8'h21);
		$display("stack done");
	endtask
	task automatic t_active_data_pointer;
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		wr(8'h84, 8'hCD);
		wr(8'h85, 8'hAB);
		chk(active_data_pointer, 16'h1234);
		wr(8'h86, 8'hFF);
		chk(active_data_pointer, 16'hABCD);
		rd(8'h86);
		chk(sfr_rdata, 8'h01);
		wr(8'h86, 8'h00);
		{active_data_pointer_load, active_data_pointer_inc, active_data_pointer_load_value} = {2'b11, 16'h00FF};
		cyc(1);
		active_data_pointer_load = 1'b0;
		chk(active_data_pointer, 16'h00FF);
		cyc(1);
		active_data_pointer_inc = 1'b0;
		rd(8'h83);
		chk(sfr_rdata, 8'h01);
		$display("pointer done");
	endtask
	task automatic t_power;
		wr(8'h87, 8'h8C);
		rd(8'h87);
		chk(sfr_rdata, 8'hBC);
		chk(baud_doubler, 1'b1);
		wr(8'h87, 8'h01);
		chk(idle_freeze, 1'b1);
		wr(8'h81, 8'h55);
		stack_push = 1'b1;
		wakeup_enable = 1'b1;
		cyc(2);
		stack_push = 1'b0;
		chk(idle_freeze, 1'b1);
		wakeup_event = 1'b1;
		cyc(1);
		wakeup_event = 1'b0;
		chk(idle_freeze, 1'b0);
		rd(8'h81);
		chk(sfr_rdata, 8'h20);
		rd(8'h87);
		chk(sfr_rdata, 8'h30);
		wr(8'h87, 8'h01);
		auxiliary_interrupt = 1'b1;
		cyc(1);
		auxiliary_interrupt = 1'b0;
		chk(idle_freeze, 1'b0);
		$display("power done");
	endtask
	task automatic t_gpio;
		wr(8'h80, 8'h5A);
		cyc(4);
		rd(8'h80);
		chk(sfr_rdata, 8'h5A);
		{port0_direction_low, port0_direction_high} = 16'h00AA;
		cyc(1);
		chk(port0_pad_oe, 8'hA0);
		{port0_direction_low, port0_direction_high} = 16'h5555;
		ext_start = 1'b1;
		cyc(1);
		ext_start = 1'b0;
		chk(addr_latch_strobe, 1'b0);
		$display("gpio done");
	endtask
	task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d);
		{ext_write, ext_addr_low, ext_wdata, ext_start} = {w, a, d, 1'b1};
		cyc(1);
		ext_start = 1'b0;
		chk(port0_pad_out, a);
		for (int i = 0; i < 8 && ext_done !== 1'b1; i++)
			cyc(1);
		chk(ext_done, 1'b1);
	endtask
	task automatic t_ext;
		hardware_config_second = 8'h00;
		cyc(1);
		chk(port0_gpio_select, 1'b0);
		ext(1'b1, 8'h12, 8'hC3);
		ext(1'b0, 8'h12, 8'h00);
		chk(ext_rdata, 8'hC3);
		hardware_config_second = 8'h02;
		$display("bus done");
	endtask
	task automatic t_stop;
		wr(8'h87, 8'h03);
		chk(osc_stop, 1'b1);
		chk(idle_freeze, 1'b0);
		rd(8'h81);
		chk(sfr_rdata, 8'h5A);
		chk(port0_pad_out, 8'h5A);
		do_reset();
		rd(8'h81);
		chk(sfr_rdata, 8'h07);
		$display("stop done");
	endtask
	initial begin
		{sys_clk, rst_b, sfr_wr, sfr_rd, stack_push, stack_pop} = '0;
		{active_data_pointer_load, active_data_pointer_inc, ext_start, ext_write} = '0;
		{auxiliary_interrupt, wakeup_enable, wakeup_event} = '0;
		{sfr_addr, sfr_wdata, active_data_pointer_load_value, ext_addr_low} = '0;
		{ext_wdata, port0_direction_low, port0_direction_high} = 24'h005555;
		{clk_en, hardware_config_second} = {1'b1, 8'h02};
		do_reset();
		t_reset();
		t_stack();
		t_active_data_pointer();
		t_power();
		t_gpio();
		t_ext();
		t_stop();
		finish_test();
	end
	// the tests need well under a thousand cycles
	initial begin
		#100000;
		errors++;
		finish_test();
	end
endmodule
